/* File: common/fpdi_defs.svh */
`ifndef FPDI_DEFS_SVH
`define FPDI_DEFS_SVH

`define FPDI_REC_BYTES      3'd5
`define FPDI_STAT_BYTE      3'd4
`define FPDI_C1_SAP         8'h33
`define FPDI_C2_SAP0        8'h00
`define FPDI_C2_SAP1        8'h01
`define FPDI_C2_SAPS        2
`define FPDI_NV_WRITES      32'd106
`define FPDI_NV_WORDS       16
`define FPDI_NV_AW          4
`define FPDI_NV_WRITE_NS    2000
`define FPDI_CLK_NS         40
`define FPDI_NV_WRITE_CYC   ((`FPDI_NV_WRITE_NS + `FPDI_CLK_NS - 1) / `FPDI_CLK_NS)
`define FPDI_BLINK_CYC      24'hBEBC20
`define FPDI_COMM_TO_CYC    24'h2625A0
`define FPDI_FLT_BIAS       8'h7F
`define FPDI_SEL_PRIMARY    2'h0
`define FPDI_SEL_SENSOR     2'h1
`define FPDI_SEL_REFERENCE  2'h2

`endif

/* File: common/fpdi_pkg.sv */
package fpdi_pkg;
    // single precision: sign, 8-bit biased exponent, 23-bit fraction
    typedef struct packed {
        logic        sign;
        logic [7:0]  exponent;
        logic [22:0] fraction;
    } fpdi_float_t;

    typedef struct packed {
        fpdi_float_t value;
        logic [7:0]  status;
    } fpdi_rec_t;

    typedef enum logic [1:0] {
        FPDI_OP_READ  = 2'h1,
        FPDI_OP_WRITE = 2'h2
    } fpdi_op_t;

    typedef enum logic [3:0] {
        FPDI_ST_IDLE = 4'b0001,
        FPDI_ST_NVWR = 4'b0010,
        FPDI_ST_RESP = 4'b0100,
        FPDI_ST_HOLD = 4'b1000
    } fpdi_state_t;
endpackage

/* File: common/fpdi_if.sv */
`timescale 1ns/10ps
interface fpdi_if;
    // cyclic exchange, byte serial: index 0..4, byte 4 is status
    logic        cyc_in_req;
    logic [2:0]  cyc_in_idx;
    logic [7:0]  cyc_in_data;
    logic        cyc_out_vld;
    logic [2:0]  cyc_out_idx;
    logic [7:0]  cyc_out_data;
    // acyclic service
    logic        acy_req;
    logic        acy_ack;
    logic [7:0]  acy_sap;
    logic [6:0]  acy_addr;
    logic [7:0]  acy_slot;
    logic [7:0]  acy_index;
    logic [7:0]  acy_len;
    logic        acy_write;
    logic [31:0] acy_wdata;
    logic [31:0] acy_rdata;
    logic        acy_err;

    modport dev (
        input  cyc_in_req, cyc_in_idx, cyc_out_vld, cyc_out_idx,
        input  cyc_out_data, acy_req, acy_sap, acy_addr, acy_slot,
        input  acy_index, acy_len, acy_write, acy_wdata,
        output cyc_in_data, acy_ack, acy_rdata, acy_err
    );
    modport mst (
        output cyc_in_req, cyc_in_idx, cyc_out_vld, cyc_out_idx,
        output cyc_out_data, acy_req, acy_sap, acy_addr, acy_slot,
        output acy_index, acy_len, acy_write, acy_wdata,
        input  cyc_in_data, acy_ack, acy_rdata, acy_err
    );
endinterface

/* File: design/fpdi_device.sv */
// Operation
// - five-byte input: float bytes 0-3, status 4
// - source_select picks primary, sensor or reference
// - accept written display value and status
// - display value never feeds measurement path
// - flash comm indicator while link active
// - values sent in configured unit_setting units
// - acyclic service never stalls cyclic exchange
// - exactly two class 2 access points
// - class 2 write: address, slot, index, length, data
// - acknowledge write only after completion
// - class 1 channel opens on access point 0x33
// - acyclic writes stored in limited non-volatile memory
// - master avoids rewriting parameters each cycle
// - master enables only processed cyclic blocks
// - master swaps float bytes if order differs
// - single precision float, exponent bias 127
`timescale 1ns/10ps
`include "fpdi_defs.svh"
module fpdi_device (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    fpdi_if.dev                       bus,
    input  wire logic [1:0]           source_select_i,
    input  wire fpdi_pkg::fpdi_float_t primary_i,
    input  wire fpdi_pkg::fpdi_float_t sensor_i,
    input  wire fpdi_pkg::fpdi_float_t reference_i,
    input  wire logic [7:0]           meas_status_i,
    input  wire logic                 sample_stb_i,
    input  wire logic [7:0]           unit_setting_i,
    output logic [31:0]               disp_value_o,
    output logic [7:0]                disp_status_o,
    output logic                      comm_led_o,
    output logic [7:0]                unit_o,
    output logic                      nv_wr_o,
    output logic [3:0]                nv_addr_o,
    output logic [31:0]               nv_data_o,
    output logic [31:0]               nv_count_o,
    output logic                      nv_worn_o
);
    import fpdi_pkg::*;

    fpdi_rec_t   in_rec_ff;
    logic [31:0] disp_shadow_ff;
    logic [31:0] disp_value_ff;
    logic [7:0]  disp_status_ff;
    logic [23:0] blink_ff;
    logic [23:0] idle_ff;
    logic        led_ff;
    fpdi_state_t state_ff;
    logic [15:0] wait_ff;
    logic [31:0] nv_count_ff;
    logic [31:0] rdata_ff;
    logic        err_ff;
    logic [31:0] nv_mem [`FPDI_NV_WORDS];
    logic        nv_wr_ff;

    localparam logic [15:0] NV_CYC = 16'(`FPDI_NV_WRITE_CYC);

    // selected source value
    wire fpdi_float_t sel_value =
        (source_select_i == `FPDI_SEL_SENSOR)    ? sensor_i :
        (source_select_i == `FPDI_SEL_REFERENCE) ? reference_i :
        primary_i;

    wire [39:0] rec_bits = in_rec_ff;
    wire [2:0]  rd_idx   = bus.cyc_in_idx;
    // byte 0 is the float msb so the sign leads
    assign bus.cyc_in_data = (rd_idx == `FPDI_STAT_BYTE) ? in_rec_ff.status :
                             (rd_idx < `FPDI_STAT_BYTE)
                             ? rec_bits[39 - 8*rd_idx -: 8]
                             : 8'h00;

    // sap decode: class 1 channel or either class 2 point
    wire sap_c1 = (bus.acy_sap == `FPDI_C1_SAP);
    wire sap_c2 = (bus.acy_sap == `FPDI_C2_SAP0) ||
                  (bus.acy_sap == `FPDI_C2_SAP1);
    wire sap_ok = sap_c1 || sap_c2;
    wire [3:0] nv_idx = bus.acy_index[3:0];
    wire idx_ok = (bus.acy_index < 8'(`FPDI_NV_WORDS)) &&
                  (bus.acy_len != 8'h00) && (bus.acy_len <= 8'h04);
    wire take   = (state_ff == FPDI_ST_IDLE) && bus.acy_req;
    wire good   = sap_ok && idx_ok;
    wire nv_end = (state_ff == FPDI_ST_NVWR) && (wait_ff == 16'h0001);

    // sample capture; write of record is atomic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_rec_ff <= '0;
        end else if (sample_stb_i) begin
            in_rec_ff <= {sel_value, meas_status_i};
        end
    end

    // display value: staged in a shadow, committed with status byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disp_shadow_ff <= '0;
            disp_value_ff  <= '0;
            disp_status_ff <= '0;
        end else if (bus.cyc_out_vld) begin
            if (bus.cyc_out_idx == `FPDI_STAT_BYTE) begin
                disp_value_ff  <= disp_shadow_ff;
                disp_status_ff <= bus.cyc_out_data;
            end else if (bus.cyc_out_idx < `FPDI_STAT_BYTE) begin
                disp_shadow_ff[31 - 8*bus.cyc_out_idx -: 8] <=
                    bus.cyc_out_data;
            end
        end
    end

    // activity: any cyclic traffic rearms a timeout
    wire cyc_act = bus.cyc_in_req || bus.cyc_out_vld;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_ff  <= '0;
            blink_ff <= '0;
            led_ff   <= 1'b0;
        end else begin
            idle_ff <= cyc_act ? `FPDI_COMM_TO_CYC :
                       (idle_ff != 24'h0) ? idle_ff - 24'h1 : 24'h0;
            if (idle_ff == 24'h0) begin
                blink_ff <= '0;
                led_ff   <= 1'b0;
            end else if (blink_ff == `FPDI_BLINK_CYC) begin
                blink_ff <= '0;
                led_ff   <= ~led_ff;
            end else begin
                blink_ff <= blink_ff + 24'h1;
            end
        end
    end

    // acyclic service runs beside, never touching the cyclic path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff    <= FPDI_ST_IDLE;
            wait_ff     <= '0;
            nv_count_ff <= '0;
            rdata_ff    <= '0;
            err_ff      <= 1'b0;
            nv_wr_ff    <= 1'b0;
        end else begin
            nv_wr_ff <= 1'b0;
            case (state_ff)
                FPDI_ST_IDLE: begin
                    if (take) begin
                        err_ff <= ~good;
                        if (good && bus.acy_write) begin
                            state_ff <= FPDI_ST_NVWR;
                            wait_ff  <= NV_CYC;
                            nv_wr_ff <= 1'b1;
                        end else begin
                            rdata_ff <= good ? nv_mem[nv_idx] : '0;
                            state_ff <= FPDI_ST_RESP;
                        end
                    end
                end
                FPDI_ST_NVWR: begin
                    wait_ff <= wait_ff - 16'h1;
                    if (nv_end) begin
                        state_ff    <= FPDI_ST_RESP;
                        nv_count_ff <= nv_count_ff + 32'h1;
                    end
                end
                FPDI_ST_RESP: state_ff <= FPDI_ST_HOLD;
                FPDI_ST_HOLD: begin
                    if (!bus.acy_req) begin
                        state_ff <= FPDI_ST_IDLE;
                    end
                end
                default: state_ff <= FPDI_ST_IDLE;
            endcase
        end
    end

    // parameter store, written once per accepted write
    always_ff @(posedge clk_i) begin
        if (take && good && bus.acy_write) begin
            nv_mem[nv_idx] <= bus.acy_wdata;
        end
    end

    logic [3:0]  nv_addr_ff;
    logic [31:0] nv_data_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nv_addr_ff <= '0;
            nv_data_ff <= '0;
        end else if (take && good && bus.acy_write) begin
            nv_addr_ff <= nv_idx;
            nv_data_ff <= bus.acy_wdata;
        end
    end

    assign bus.acy_ack   = (state_ff == FPDI_ST_RESP);
    assign bus.acy_rdata = rdata_ff;
    assign bus.acy_err   = err_ff;
    // display value is exported only, no path back to measurement
    assign disp_value_o  = disp_value_ff;
    assign disp_status_o = disp_status_ff;
    assign comm_led_o    = led_ff;
    assign unit_o        = unit_setting_i;
    assign nv_wr_o       = nv_wr_ff;
    assign nv_addr_o     = nv_addr_ff;
    assign nv_data_o     = nv_data_ff;
    assign nv_count_o    = nv_count_ff;
    // endurance budget: flag once the rated count is reached
    assign nv_worn_o     = (nv_count_ff >= `FPDI_NV_WRITES);
endmodule

/* File: design/fpdi_master.sv */
`timescale 1ns/10ps
`include "fpdi_defs.svh"
module fpdi_master (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    fpdi_if.mst              bus,
    input  wire logic        poll_i,
    input  wire logic        in_enable_i,
    input  wire logic        out_enable_i,
    input  wire logic        swap_i,
    input  wire logic [31:0] disp_value_i,
    input  wire logic [7:0]  disp_status_i,
    output logic [31:0]      value_o,
    output logic [7:0]       status_o,
    output logic             rec_vld_o,
    input  wire logic        acy_go_i,
    input  wire logic        acy_class1_i,
    input  wire logic        acy_sap_sel_i,
    input  wire logic        acy_write_i,
    input  wire logic [6:0]  acy_addr_i,
    input  wire logic [7:0]  acy_slot_i,
    input  wire logic [7:0]  acy_index_i,
    input  wire logic [31:0] acy_wdata_i,
    output logic             acy_busy_o,
    output logic             acy_done_o,
    output logic [31:0]      acy_rdata_o,
    output logic             acy_err_o
);
    import fpdi_pkg::*;

    logic        run_ff;
    logic [2:0]  idx_ff;
    logic [39:0] rx_ff;
    logic [31:0] value_ff;
    logic [7:0]  status_ff;
    logic        vld_ff;
    logic        req_ff;
    logic [7:0]  sap_ff;
    logic [6:0]  addr_ff;
    logic [7:0]  slot_ff;
    logic [7:0]  index_ff;
    logic        write_ff;
    logic [31:0] wdata_ff;
    logic        done_ff;
    logic [31:0] rdata_ff;
    logic        err_ff;
    logic [39:0] tx_rec;

    wire last = (idx_ff == `FPDI_STAT_BYTE);
    assign tx_rec = {disp_value_i, disp_status_i};
    // only blocks the program uses are exchanged
    assign bus.cyc_in_req   = run_ff && in_enable_i;
    assign bus.cyc_in_idx   = idx_ff;
    assign bus.cyc_out_vld  = run_ff && out_enable_i;
    assign bus.cyc_out_idx  = idx_ff;
    assign bus.cyc_out_data = tx_rec[39 - 8*idx_ff -: 8];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_ff    <= 1'b0;
            idx_ff    <= '0;
            rx_ff     <= '0;
            value_ff  <= '0;
            status_ff <= '0;
            vld_ff    <= 1'b0;
        end else begin
            vld_ff <= 1'b0;
            if (!run_ff) begin
                run_ff <= poll_i;
                idx_ff <= '0;
            end else begin
                rx_ff[39 - 8*idx_ff -: 8] <= bus.cyc_in_data;
                idx_ff <= last ? 3'h0 : idx_ff + 3'h1;
                run_ff <= !last;
                if (last && in_enable_i) begin
                    value_ff  <= swap_i ? {rx_ff[15:8], rx_ff[23:16],
                                 rx_ff[31:24], rx_ff[39:32]}
                               : rx_ff[39:8];
                    status_ff <= bus.cyc_in_data;
                    vld_ff    <= 1'b1;
                end
            end
        end
    end

    // one request at a time, held until acknowledged
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_ff   <= 1'b0;
            sap_ff   <= '0;
            addr_ff  <= '0;
            slot_ff  <= '0;
            index_ff <= '0;
            write_ff <= 1'b0;
            wdata_ff <= '0;
            done_ff  <= 1'b0;
            rdata_ff <= '0;
            err_ff   <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            // only an explicit go issues a request, never every cycle
            if (!req_ff && acy_go_i) begin
                req_ff   <= 1'b1;
                sap_ff   <= acy_class1_i ? `FPDI_C1_SAP :
                            acy_sap_sel_i ? `FPDI_C2_SAP1
                                          : `FPDI_C2_SAP0;
                addr_ff  <= acy_addr_i;
                slot_ff  <= acy_slot_i;
                index_ff <= acy_index_i;
                write_ff <= acy_write_i;
                wdata_ff <= acy_wdata_i;
            end else if (req_ff && bus.acy_ack) begin
                req_ff   <= 1'b0;
                done_ff  <= 1'b1;
                rdata_ff <= bus.acy_rdata;
                err_ff   <= bus.acy_err;
            end
        end
    end

    assign bus.acy_req   = req_ff;
    assign bus.acy_sap   = sap_ff;
    assign bus.acy_addr  = addr_ff;
    assign bus.acy_slot  = slot_ff;
    assign bus.acy_index = index_ff;
    assign bus.acy_len   = 8'h04;
    assign bus.acy_write = write_ff;
    assign bus.acy_wdata = wdata_ff;
    assign value_o       = value_ff;
    assign status_o      = status_ff;
    assign rec_vld_o     = vld_ff;
    assign acy_busy_o    = req_ff;
    assign acy_done_o    = done_ff;
    assign acy_rdata_o   = rdata_ff;
    assign acy_err_o     = err_ff;
endmodule

/* File: tb/fpdi_chk_sva.sv */
`timescale 1ns/10ps
module fpdi_chk (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_in_req,
    input  wire logic [2:0]  cyc_in_idx,
    input  wire logic        cyc_out_vld,
    input  wire logic [2:0]  cyc_out_idx,
    input  wire logic        acy_req,
    input  wire logic        acy_ack,
    input  wire logic [7:0]  acy_sap,
    input  wire logic [7:0]  acy_len,
    input  wire logic        acy_write,
    input  wire logic [31:0] acy_wdata
);
    // cycles a request has been standing, saturates well past the write wait
    logic [6:0] wait_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i || !acy_req)
            wait_ff <= 7'h00;
        else if (wait_ff != 7'h7F)
            wait_ff <= wait_ff + 7'h01;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    in_order_a: assert property (cyc_in_req && cyc_in_idx < 3'h4 |=>
        cyc_in_req && cyc_in_idx == $past(cyc_in_idx) + 3'h1)
        else $error("input bytes out of order");
    in_end_a: assert property (cyc_in_req && cyc_in_idx == 3'h4 |=>
        !cyc_in_req) else $error("input run longer than five bytes");
    out_order_a: assert property (cyc_out_vld && cyc_out_idx < 3'h4 |=>
        cyc_out_vld && cyc_out_idx == $past(cyc_out_idx) + 3'h1)
        else $error("output bytes out of order");
    rd_ack_a: assert property ($rose(acy_req) && !acy_write |=> acy_ack)
        else $error("read not answered next cycle");
    // a refused write answers after one cycle, a stored one after the NV wait
    wr_ack_a: assert property (acy_ack && acy_write |->
        wait_ff == 7'h33 || wait_ff == 7'h01)
        else $error("write acknowledged at wrong time");
    ack_bound_a: assert property ($rose(acy_req) |-> ##[1:60] acy_ack)
        else $error("request never acknowledged");
    ack_pulse_a: assert property (acy_ack |=> !acy_ack && !acy_req)
        else $error("ack not a single pulse or request held");
    req_hold_a: assert property (acy_req && !acy_ack |=> acy_req &&
        $stable(acy_wdata) && $stable(acy_write) && $stable(acy_sap))
        else $error("request changed before ack");
    sap_legal_a: assert property (acy_req |->
        acy_sap inside {8'h33, 8'h00, 8'h01} && acy_len inside {[8'h01:8'h04]})
        else $error("illegal access point or length");

    cover property ($rose(acy_req) && acy_write);
    cover property (acy_ack && !acy_write);
    cover property (acy_req && cyc_in_req);
    cover property (cyc_in_req && cyc_out_vld && cyc_in_idx == 3'h4);
endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        fails++; \
        $display("mismatch at %0t: got %h exp %h", $time, a, b); \
    end \
end

module tb;
    import fpdi_pkg::*;
    int          samples_checked = 0;
    int          fails = 0;
    int          nv_pulses = 0;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [1:0]  src;
    fpdi_float_t prim, sens, refv;
    logic [7:0]  mstat, unit, disp_s, unit_w, ds, stat, ix;
    logic        stb, led, nv_wr, worn, poll, swap, go, c1, ssel, wr;
    logic        rvld, busy, done, err, in_en, out_en;
    logic [3:0]  nv_addr;
    logic [31:0] disp_v, nv_data, nv_cnt, wd, dv, val, rdata;
    logic [31:0] pick [4] = '{32'h40F00000, 32'hC1200000, 32'h41C80000,
                              32'h40F00000};

    always #20 clk_i = ~clk_i;

    // store strobe is one cycle wide, so each negedge sees a pulse once
    always @(negedge clk_i)
        if (nv_wr === 1'b1)
            nv_pulses++;

    fpdi_if link ();
    fpdi_device fpdi_device_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link),
        .source_select_i(src), .primary_i(prim), .sensor_i(sens),
        .reference_i(refv), .meas_status_i(mstat), .sample_stb_i(stb),
        .unit_setting_i(unit), .disp_value_o(disp_v), .disp_status_o(disp_s),
        .comm_led_o(led), .unit_o(unit_w), .nv_wr_o(nv_wr),
        .nv_addr_o(nv_addr), .nv_data_o(nv_data), .nv_count_o(nv_cnt),
        .nv_worn_o(worn));
    fpdi_master fpdi_master_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link),
        .poll_i(poll), .in_enable_i(in_en), .out_enable_i(out_en),
        .swap_i(swap), .disp_value_i(dv), .disp_status_i(ds), .value_o(val),
        .status_o(stat), .rec_vld_o(rvld), .acy_go_i(go), .acy_class1_i(c1),
        .acy_sap_sel_i(ssel), .acy_write_i(wr), .acy_addr_i(7'h12),
        .acy_slot_i(8'h01), .acy_index_i(ix), .acy_wdata_i(wd),
        .acy_busy_o(busy), .acy_done_o(done), .acy_rdata_o(rdata),
        .acy_err_o(err));
    fpdi_chk fpdi_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_in_req(link.cyc_in_req), .cyc_in_idx(link.cyc_in_idx),
        .cyc_out_vld(link.cyc_out_vld), .cyc_out_idx(link.cyc_out_idx),
        .acy_req(link.acy_req), .acy_ack(link.acy_ack),
        .acy_sap(link.acy_sap), .acy_len(link.acy_len),
        .acy_write(link.acy_write), .acy_wdata(link.acy_wdata));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic poll_rec(input logic [31:0] ev, input logic [7:0] es);
        int n;
        n = 0;
        poll = 1'b1;
        @(negedge clk_i);
        poll = 1'b0;
        while (rvld !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        `CHK(rvld, 1'b1)
        `CHK(val, ev)
        `CHK(stat, es)
        repeat (2) @(negedge clk_i);
    endtask

    task automatic acy(input logic cls, sel, w, input logic [7:0] x,
                       input logic [31:0] d, er, input logic ee);
        int n;
        n = 0;
        c1 = cls;
        ssel = sel;
        wr = w;
        ix = x;
        wd = d;
        go = 1'b1;
        @(negedge clk_i);
        go = 1'b0;
        `CHK(busy, 1'b1)
        while (done !== 1'b1 && n < 80) begin
            @(negedge clk_i);
            n++;
        end
        `CHK(done, 1'b1)
        `CHK(err, ee)
        if (!w && !ee)
            `CHK(rdata, er)
        repeat (3) @(negedge clk_i);
    endtask

    initial begin
        {src, stb, poll, swap, go, c1, ssel, wr} = '0;
        {in_en, out_en} = 2'h3;
        prim = 32'h40F00000;
        sens = 32'hC1200000;
        refv = 32'h41C80000;
        {mstat, ds, ix, wd, dv} = '0;
        unit = 8'h21;
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        `CHK(unit_w, 8'h21)
        `CHK(led, 1'b0)
        unit = 8'h2A;
        // display value differs from every source, so leakage shows in val
        for (int i = 0; i < 4; i++) begin
            src = i[1:0];
            mstat = 8'h80 + 8'(i);
            dv = 32'h3F800000 + 32'(i);
            ds = 8'h40 + 8'(i);
            stb = 1'b1;
            @(negedge clk_i);
            stb = 1'b0;
            poll_rec(pick[i], mstat);
            `CHK(disp_v, dv)
            `CHK(disp_s, ds)
        end
        $display("test source and display done");
        `CHK(unit_w, 8'h2A)
        prim = 32'h42000000;
        mstat = 8'h11;
        poll_rec(32'h40F00000, 8'h83);
        // 7.5 carries exponent 2, so the biased field reads 129
        `CHK(val[30:23], 8'h81)
        stb = 1'b1;
        @(negedge clk_i);
        stb = 1'b0;
        poll_rec(32'h42000000, 8'h11);
        swap = 1'b1;
        poll_rec(32'h00000042, 8'h11);
        swap = 1'b0;
        // output block alone: display moves, input value stays put
        {in_en, out_en} = 2'h1;
        dv = 32'h3F000000;
        ds = 8'h55;
        poll = 1'b1;
        @(negedge clk_i);
        poll = 1'b0;
        repeat (8) @(negedge clk_i);
        `CHK(disp_v, 32'h3F000000)
        `CHK(disp_s, 8'h55)
        `CHK(val, 32'h00000042)
        // input block alone: display must not move
        {in_en, out_en} = 2'h2;
        dv = 32'h3E800000;
        poll_rec(32'h42000000, 8'h11);
        `CHK(disp_v, 32'h3F000000)
        {in_en, out_en} = 2'h3;
        $display("test record capture done");
        acy(1'b0, 1'b0, 1'b1, 8'h03, 32'h12345678, '0, 1'b0);
        `CHK(nv_addr, 4'h3)
        `CHK(nv_data, 32'h12345678)
        acy(1'b0, 1'b1, 1'b0, 8'h03, '0, 32'h12345678, 1'b0);
        acy(1'b1, 1'b0, 1'b1, 8'h0F, 32'hA5A50F0F, '0, 1'b0);
        acy(1'b1, 1'b0, 1'b0, 8'h0F, '0, 32'hA5A50F0F, 1'b0);
        acy(1'b0, 1'b0, 1'b0, 8'h20, '0, '0, 1'b1);
        acy(1'b0, 1'b1, 1'b1, 8'h10, 32'h00000001, '0, 1'b1);
        `CHK(nv_cnt, 32'h00000002)
        `CHK(worn, 1'b0)
        `CHK(nv_pulses, 2)
        $display("test acyclic access done");
        fork
            acy(1'b0, 1'b1, 1'b0, 8'h03, '0, 32'h12345678, 1'b0);
            poll_rec(32'h42000000, 8'h11);
        join
        $display("test concurrent exchange done");
        report_and_stop();
    end

    // whole sequence takes well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        report_and_stop();
    end
endmodule
